// ---- hdl/relative_branch_decode_execute.sv ----
// decode and execute of the counter-relative branch instructions
//
// Contract
// [RL1] Upper byte 1110 0110 branches when the negative flag is one, low byte is the offset.
// [RL2] Upper byte 1110 0011 branches when the carry flag is zero, low byte is the offset.
// [RL3] Upper byte 1110 0111 branches when the negative flag is zero, low byte is the offset.
// [RL4] Upper byte 1110 0101 branches when the overflow flag is zero, low byte is the offset.
// [RL5] Upper byte 1110 0001 branches when the zero flag is zero, low byte is the offset.
// [RL6] Upper five bits 11010 branch always, with an eleven-bit signed offset from -1024 to 1023.
// [RL7] A conditional offset is a signed byte from -128 to 127, sign extended before use.
// [RL8] A taken branch loads the counter with branch address plus 2 plus twice the offset.
// [RL9] The target is built from the incremented counter, not the branch address itself.
// [RL10] A conditional branch takes one cycle when not taken and two when taken, the second idle.
// [RL11] The unconditional branch always takes two cycles, loading the counter after the first.
// [RL12] No relative branch changes any status flag; flags are only read.
`include "branch_cfg.svh"

module relative_branch_decode_execute #(
  parameter int PC_W = `RB_PC_W
) (
  input  wire logic                   clk,             // core clock, 25 MHz
  input  wire logic                   rst,             // synchronous reset, active high
  input  wire logic                   instr_valid,     // fetch offers an instruction
  input  wire logic [`RB_INSTR_W-1:0] instr_word,      // offered instruction word
  input  wire logic [PC_W-1:0]        pc_next,         // counter already advanced past it
  input  wire logic                   flag_neg,        // negative status flag
  input  wire logic                   flag_carry,      // carry status flag
  input  wire logic                   flag_ovf,        // overflow status flag
  input  wire logic                   flag_zero,       // zero status flag
  output logic                        instr_ready,     // block accepts an instruction
  output logic                        nop_cycle,       // refill cycle after a taken branch
  output logic                        pc_load_q,       // one-cycle counter load strobe
  output logic [PC_W-1:0]             pc_target_q,     // counter value to load
  output logic                        taken_q,         // pulse, a branch was taken
  output logic                        not_taken_q,     // pulse, a branch fell through
  output logic                        status_write_en  // status flag write, never asserted
);
  import branch_pkg::*;

  state_t          state_q;
  state_t          state_d;
  op_kind_t        kind;
  logic            cond_met;
  logic [PC_W-1:0] target;
  logic            fire;
  logic            is_branch;
  logic            take;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  branch_decode #(
    .PC_W (PC_W)
  ) u_decode (
    .instr_word (instr_word),
    .pc_next    (pc_next),
    .flag_neg   (flag_neg),
    .flag_carry (flag_carry),
    .flag_ovf   (flag_ovf),
    .flag_zero  (flag_zero),
    .kind       (kind),
    .cond_met   (cond_met),
    .target     (target)
  );

  assign fire      = instr_valid && instr_ready;
  assign is_branch = (kind != K_NONE);
  assign take      = fire && is_branch && cond_met;

  // this block owns no path into the status register
  assign status_write_en = 1'b0; // RL12

  ////////////////////////////////////////////////////////////////////////////
  // sequencing

  // the refill cycle refuses new work so fetch holds the next word
  assign instr_ready = (state_q == ST_IDLE);
  assign nop_cycle   = (state_q == ST_FLUSH);

  always_comb begin
    case (state_q)
      ST_IDLE: begin
        if (take) begin
          state_d = ST_FLUSH; // RL10 RL11
        end else begin
          state_d = ST_IDLE;  // RL10
        end
      end
      ST_FLUSH: state_d = ST_IDLE; // RL10 RL11
      default:  state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter load

  always_ff @(posedge clk) begin
    if (rst) begin
      pc_load_q   <= `RB_PULSE_RST;
      pc_target_q <= PC_W'(`RB_TARGET_RST);
    end else begin
      pc_load_q <= take; // RL8 RL11
      if (take) begin
        pc_target_q <= target; // RL8 RL9
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      taken_q     <= `RB_PULSE_RST;
      not_taken_q <= `RB_PULSE_RST;
    end else begin
      taken_q     <= take;
      not_taken_q <= fire && is_branch && !cond_met; // RL10
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic [`RB_INSTR_W-1:0] w_chk;
  logic [PC_W-1:0]        exp_cond_target;
  logic [PC_W-1:0]        exp_bra_target;
  logic                   bra_word;
  logic                   cond_word;
  logic [1:0]             busy_cnt;

  assign w_chk           = instr_word;
  assign bra_word        = (w_chk[15:11] == 5'b11010);
  // decoded apart from the classify function so a broken table still shows up here
  assign cond_word       = w_chk[15:8] inside {`RB_OP_NEG_SET, `RB_OP_CARRY_CLR, `RB_OP_NEG_CLR,
                                               `RB_OP_OVF_CLR, `RB_OP_ZERO_CLR};
  assign exp_cond_target = pc_next + PC_W'({{(PC_W-8){w_chk[7]}}, w_chk[7:0]} << 1);
  assign exp_bra_target  = pc_next + PC_W'({{(PC_W-11){w_chk[10]}}, w_chk[10:0]} << 1);

  // counts cycles spent per accepted branch
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_cnt <= 2'd0;
    end else if (fire && is_branch) begin
      busy_cnt <= 2'd1;
    end else if (state_q == ST_FLUSH) begin
      busy_cnt <= 2'd2;
    end else begin
      busy_cnt <= 2'd0;
    end
  end

  a_neg_set_take: assert property ( // RL1
    fire && w_chk[15:8] == 8'he6 |=> pc_load_q == $past(flag_neg))
    else $error("negative-set branch condition wrong");

  a_carry_clr_take: assert property ( // RL2
    fire && w_chk[15:8] == 8'he3 |=> pc_load_q == !$past(flag_carry))
    else $error("carry-clear branch condition wrong");

  a_neg_clr_take: assert property ( // RL3
    fire && w_chk[15:8] == 8'he7 |=> pc_load_q == !$past(flag_neg))
    else $error("negative-clear branch condition wrong");

  a_ovf_clr_take: assert property ( // RL4
    fire && w_chk[15:8] == 8'he5 |=> pc_load_q == !$past(flag_ovf))
    else $error("overflow-clear branch condition wrong");

  a_zero_clr_take: assert property ( // RL5
    fire && w_chk[15:8] == 8'he1 |=> pc_load_q == !$past(flag_zero))
    else $error("zero-clear branch condition wrong");

  property p_bra_target;
    logic [PC_W-1:0] t;
    (fire && bra_word, t = exp_bra_target) |=> pc_load_q && pc_target_q == t;
  endproperty
  a_bra_target: assert property (p_bra_target) // RL6
    else $error("unconditional branch target wrong");

  property p_cond_target;
    logic [PC_W-1:0] t;
    (take && !bra_word, t = exp_cond_target) |=> pc_target_q == t;
  endproperty
  a_cond_target: assert property (p_cond_target) // RL7 RL8 RL9
    else $error("conditional branch target wrong");

  a_fall_through: assert property ( // RL10
    fire && is_branch && !cond_met |=> !pc_load_q && instr_ready && not_taken_q)
    else $error("untaken branch did not finish in one cycle");

  a_taken_two_cycle: assert property ( // RL10
    take |=> (nop_cycle && !instr_ready && pc_load_q) ##1 (instr_ready && !pc_load_q))
    else $error("taken branch did not use exactly two cycles");

  a_bra_two_cycle: assert property ( // RL11
    fire && bra_word |=> nop_cycle && taken_q ##1 !nop_cycle)
    else $error("unconditional branch not two cycles");

  a_busy_bound: assert property ( // RL10 RL11
    busy_cnt == 2'd2 |-> $past(busy_cnt) == 2'd1 && $past(pc_load_q, 1) == 1'b1)
    else $error("refill cycle without a preceding branch");

  a_no_flag_write: assert property ( // RL12
    fire && is_branch |-> !status_write_en [*2])
    else $error("branch wrote a status flag");

  // one-hot codes: a stray state code would hold off fetch for one cycle before the default returns to ST_IDLE, so catch it at once
  a_kind_one_hot: assert property ( // RL1 RL6
    $onehot(kind))
    else $error("decoded branch kind not one-hot");

  a_state_one_hot: assert property ( // RL10
    $onehot(state_q))
    else $error("sequencer state not one-hot");

  a_pulse_exclusive: assert property ( // RL10
    !(taken_q && not_taken_q))
    else $error("taken and not-taken pulses together");

  a_ignored_word: assert property ( // RL6
    fire && !bra_word && !cond_word |=> !pc_load_q && !taken_q && !not_taken_q && instr_ready)
    else $error("non-branch word produced a branch pulse");

  a_target_hold: assert property ( // RL8
    !pc_load_q |-> $stable(pc_target_q))
    else $error("target moved without a load");

  a_taken_single: assert property ( // RL10 RL11
    taken_q |=> !taken_q && !not_taken_q)
    else $error("second branch pulse inside the refill cycle");

  a_refill_refuses: assert property ( // RL10
    nop_cycle && instr_valid |=> !taken_q && !not_taken_q)
    else $error("word accepted during the refill cycle");

  a_bra_no_fallthru: assert property ( // RL11
    fire && bra_word |=> !not_taken_q && pc_load_q)
    else $error("unconditional branch fell through");

  a_idle_no_pulse: assert property ( // RL10
    instr_ready && !instr_valid |=> !pc_load_q && !taken_q && !not_taken_q)
    else $error("branch pulse without an accepted word");

  c_cond_taken: cover property (fire && is_branch && !bra_word && cond_met);
  c_cond_untaken: cover property (fire && is_branch && !cond_met);
  c_bra: cover property (fire && bra_word ##2 fire);
  c_back_to_back: cover property (fire && is_branch && !cond_met ##1 fire && is_branch);
  c_refill_wait: cover property (nop_cycle && instr_valid);

endmodule

// ---- include/branch_cfg.svh ----
// constants for the relative branch decode and execute block
`ifndef BRANCH_CFG_SVH
`define BRANCH_CFG_SVH

// instruction word layout
`define RB_INSTR_W        16
`define RB_OPC_HI         15
`define RB_OPC_LO         8
`define RB_BRA_TOP_HI     15
`define RB_BRA_TOP_LO     11
`define RB_COND_OFF_W     8
`define RB_BRA_OFF_W      11

// opcode upper bytes of the conditional branches
`define RB_OP_NEG_SET     8'he6
`define RB_OP_CARRY_CLR   8'he3
`define RB_OP_NEG_CLR     8'he7
`define RB_OP_OVF_CLR     8'he5
`define RB_OP_ZERO_CLR    8'he1

// upper five bits of the unconditional branch
`define RB_OP_BRA_TOP     5'h1a

// program counter width and reset values
`define RB_PC_W           21
`define RB_TARGET_RST     21'h00_0000
`define RB_PULSE_RST      1'b0

// instruction cycle counts
`define RB_CYC_NOT_TAKEN  1
`define RB_CYC_TAKEN      2

`endif

// ---- include/branch_pkg.sv ----
// types shared by the relative branch decode and execute block
package branch_pkg;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_FLUSH = 2'b10
  } state_t;

  typedef enum logic [6:0] {
    K_NONE                     = 7'b000_0001,
    K_BRANCH_IF_NEGATIVE_SET   = 7'b000_0010,
    K_BRANCH_IF_CARRY_CLEAR    = 7'b000_0100,
    K_BRANCH_IF_NEGATIVE_CLEAR = 7'b000_1000,
    K_BRANCH_IF_OVERFLOW_CLEAR = 7'b001_0000,
    K_BRANCH_IF_ZERO_CLEAR     = 7'b010_0000,
    K_BRANCH_ALWAYS_RELATIVE   = 7'b100_0000
  } op_kind_t;

endpackage

// ---- hdl/branch_decode.sv ----
// opcode classification, condition test and target arithmetic
`include "branch_cfg.svh"

module branch_decode #(
  parameter int PC_W = `RB_PC_W
) (
  input  wire logic [`RB_INSTR_W-1:0] instr_word,  // instruction under decode
  input  wire logic [PC_W-1:0]        pc_next,     // counter already past the branch
  input  wire logic                   flag_neg,    // negative status flag
  input  wire logic                   flag_carry,  // carry status flag
  input  wire logic                   flag_ovf,    // overflow status flag
  input  wire logic                   flag_zero,   // zero status flag
  output branch_pkg::op_kind_t        kind,        // decoded branch kind
  output logic                        cond_met,    // branch would be taken
  output logic [PC_W-1:0]             target       // taken destination
);
  import branch_pkg::*;

  logic [PC_W-1:0] offset2;

  function automatic op_kind_t classify(input logic [`RB_INSTR_W-1:0] w);
    op_kind_t k;
    k = K_NONE;
    if (w[`RB_BRA_TOP_HI:`RB_BRA_TOP_LO] == `RB_OP_BRA_TOP) begin
      k = K_BRANCH_ALWAYS_RELATIVE; // RL6
    end else begin
      case (w[`RB_OPC_HI:`RB_OPC_LO])
        `RB_OP_NEG_SET:   k = K_BRANCH_IF_NEGATIVE_SET;   // RL1
        `RB_OP_CARRY_CLR: k = K_BRANCH_IF_CARRY_CLEAR;    // RL2
        `RB_OP_NEG_CLR:   k = K_BRANCH_IF_NEGATIVE_CLEAR; // RL3
        `RB_OP_OVF_CLR:   k = K_BRANCH_IF_OVERFLOW_CLEAR; // RL4
        `RB_OP_ZERO_CLR:  k = K_BRANCH_IF_ZERO_CLEAR;     // RL5
        default:          k = K_NONE;
      endcase
    end
    return k;
  endfunction

  assign kind = classify(instr_word);

  // flags are only looked at, never written
  always_comb begin
    case (kind)
      K_BRANCH_IF_NEGATIVE_SET:   cond_met = flag_neg;    // RL1
      K_BRANCH_IF_CARRY_CLEAR:    cond_met = !flag_carry; // RL2
      K_BRANCH_IF_NEGATIVE_CLEAR: cond_met = !flag_neg;   // RL3
      K_BRANCH_IF_OVERFLOW_CLEAR: cond_met = !flag_ovf;   // RL4
      K_BRANCH_IF_ZERO_CLEAR:     cond_met = !flag_zero;  // RL5
      K_BRANCH_ALWAYS_RELATIVE:   cond_met = 1'b1;        // RL11
      default:                    cond_met = 1'b0;
    endcase
  end

  // sign extend then double; word-aligned offsets in a byte-addressed counter
  always_comb begin
    if (kind == K_BRANCH_ALWAYS_RELATIVE) begin
      offset2 = {{(PC_W-`RB_BRA_OFF_W-1){instr_word[`RB_BRA_OFF_W-1]}},
                 instr_word[`RB_BRA_OFF_W-1:0], 1'b0}; // RL6
    end else begin
      offset2 = {{(PC_W-`RB_COND_OFF_W-1){instr_word[`RB_COND_OFF_W-1]}},
                 instr_word[`RB_COND_OFF_W-1:0], 1'b0}; // RL7
    end
  end

  // base is the incremented counter, so this is branch address + 2 + 2n
  assign target = pc_next + offset2; // RL8 RL9

endmodule

// ---- verif/fetch_model.sv ----
// behavioural fetch stage and program counter facing the branch block
module fetch_model #(
  parameter int              PC_W  = 21,
  parameter logic [PC_W-1:0] START = '0
) (
  input  wire logic            clk,          // core clock
  input  wire logic            rst,          // synchronous reset, active high
  input  wire logic            instr_valid,  // word offered by the bench
  input  wire logic            instr_ready,  // block accepts the word
  input  wire logic            pc_load_q,    // load strobe from the block
  input  wire logic [PC_W-1:0] pc_target_q,  // value to load
  output logic [PC_W-1:0]      pc_q,         // address of the offered word
  output logic [PC_W-1:0]      pc_next       // counter already past it
);
  timeunit 1ns;
  timeprecision 1ps;

  assign pc_next = pc_q + PC_W'(2);

  // a load wins over a step; the block never accepts in its load cycle anyway
  always_ff @(posedge clk) begin
    if (rst) begin
      pc_q <= START;
    end else if (pc_load_q) begin
      pc_q <= pc_target_q;
    end else if (instr_valid && instr_ready) begin
      pc_q <= pc_next;
    end
  end
endmodule

// ---- verif/relative_branch_decode_execute_tb.sv ----
// self-checking bench for the relative branch decode and execute block
module relative_branch_decode_execute_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PW = 21;

  logic          clk         = 1'b0;
  logic          rst         = 1'b1;
  logic          instr_valid = 1'b0;
  logic [15:0]   instr_word  = 16'h0000;
  logic [3:0]    fl          = 4'h0;
  logic [PW-1:0] pc_next;
  logic [PW-1:0] pc_q;
  logic [PW-1:0] pc_target_q;
  logic          instr_ready;
  logic          nop_cycle;
  logic          pc_load_q;
  logic          taken_q;
  logic          not_taken_q;
  logic          status_write_en;
  int            failures    = 0;
  int            n_checks    = 0;

  always #20 clk = ~clk;

  // start near the top so forward branches wrap the counter
  fetch_model #(.PC_W(PW), .START(21'h1f_fff0)) fm (
    .clk(clk), .rst(rst), .instr_valid(instr_valid), .instr_ready(instr_ready),
    .pc_load_q(pc_load_q), .pc_target_q(pc_target_q), .pc_q(pc_q), .pc_next(pc_next));

  relative_branch_decode_execute #(.PC_W(PW)) dut (
    .clk(clk), .rst(rst), .instr_valid(instr_valid), .instr_word(instr_word), .pc_next(pc_next),
    .flag_neg(fl[3]), .flag_carry(fl[2]), .flag_ovf(fl[1]), .flag_zero(fl[0]),
    .instr_ready(instr_ready), .nop_cycle(nop_cycle), .pc_load_q(pc_load_q),
    .pc_target_q(pc_target_q), .taken_q(taken_q), .not_taken_q(not_taken_q),
    .status_write_en(status_write_en));

  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic summarize();
    if (failures == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // one word, then the answer cycle and the cycle after it
  task automatic issue(input logic [15:0] w, input logic [3:0] f, input bit tk, input bit nt);
    int            off;
    logic [PW-1:0] pn;
    logic [PW-1:0] exp_t;
    off = (w[15:11] == 5'h1a) ? int'($signed(w[10:0])) : int'($signed(w[7:0]));
    @(negedge clk);
    instr_valid = 1'b1;
    instr_word  = w;
    fl          = f;
    pn          = pc_next;
    exp_t       = pn + PW'(2 * off);
    @(negedge clk);
    instr_valid = 1'b0;
    chk("pulses", 32'({tk, tk, nt, tk, !tk}), 32'({taken_q, pc_load_q, not_taken_q, nop_cycle, instr_ready}));
    chk("status_write_en", 32'h0, 32'(status_write_en));
    if (tk) chk("pc_target_q", 32'(exp_t), 32'(pc_target_q));
    @(negedge clk);
    chk("idle", 32'h1, 32'({taken_q, pc_load_q, not_taken_q, nop_cycle, instr_ready}));
    chk("pc_q", 32'(tk ? exp_t : pn), 32'(pc_q));
  endtask

  // other flags sit where a wrongly chosen flag would flip the outcome
  task automatic cond_all();
    logic [7:0] op [5]  = '{8'he6, 8'he3, 8'he7, 8'he5, 8'he1};
    int         idx [5] = '{3, 2, 3, 1, 0};
    bit         lvl [5] = '{1, 0, 0, 0, 0};
    logic [3:0] f;
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 5; i++) begin
        f = lvl[i] ? 4'h0 : 4'hf;
        f[idx[i]] = lvl[i];
        issue({op[i], p ? 8'h7f : 8'h80}, f, 1'b1, 1'b0);
        f = ~f;
        issue({op[i], p ? 8'h80 : 8'h7f}, f, 1'b0, 1'b1);
      end
    end
  endtask

  task automatic always_and_ignored();
    issue(16'hd400, 4'h0, 1'b1, 1'b0);
    issue(16'hd3ff, 4'hf, 1'b1, 1'b0);
    issue(16'hd7ff, 4'h5, 1'b1, 1'b0);
    issue(16'hd805, 4'h4, 1'b0, 1'b0);
    issue(16'he205, 4'h4, 1'b0, 1'b0);
    issue(16'he405, 4'h0, 1'b0, 1'b0);
  endtask

  task automatic b2b();
    @(negedge clk);
    instr_valid = 1'b1;
    instr_word  = 16'he100;
    fl          = 4'h1;
    @(negedge clk);
    instr_word  = 16'he301;
    fl          = 4'h4;
    chk("first", 32'h6, 32'({not_taken_q, instr_ready, taken_q}));
    @(negedge clk);
    instr_valid = 1'b0;
    chk("second", 32'h6, 32'({not_taken_q, instr_ready, taken_q}));
  endtask

  // a word offered in the refill cycle waits one more edge
  task automatic refuse();
    @(negedge clk);
    instr_valid = 1'b1;
    instr_word  = 16'hd001;
    @(negedge clk);
    instr_word  = 16'he700;
    fl          = 4'h8;
    chk("refill", 32'h2, 32'({taken_q, instr_ready}));
    @(negedge clk);
    chk("held", 32'h1, 32'({taken_q, not_taken_q, instr_ready}));
    @(negedge clk);
    instr_valid = 1'b0;
    chk("late", 32'h1, 32'(not_taken_q));
  endtask

  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk("reset outs", 32'h1, 32'({taken_q, pc_load_q, not_taken_q, nop_cycle, instr_ready}));
    rst = 1'b0;
    cond_all();
    always_and_ignored();
    b2b();
    refuse();
    summarize();
  end

  initial begin
    #20000;
    failures++;
    summarize();
  end
endmodule
